//--- common/gcl_pkg.sv
/*
 * constants, reset values and state codes for the port configuration and lock block.
 * assumes a 32-bit avalon-mm register bus and two ports of up to sixteen pins each.
 */
package gcl_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [31:0] GCL_BASE_A   = 32'h4000_1C00;
    localparam logic [31:0] GCL_BASE_B   = 32'h4000_2000;
    localparam logic [31:0] GCL_WIN_MASK = 32'hFFFF_FC00;
    localparam int          GCL_OFS_W    = 10;

    localparam logic [9:0] GCL_OFS_MODE  = 10'h000;
    localparam logic [9:0] GCL_OFS_OTYPE = 10'h004;
    localparam logic [9:0] GCL_OFS_SR    = 10'h008;
    localparam logic [9:0] GCL_OFS_PUPD  = 10'h00C;
    localparam logic [9:0] GCL_OFS_DS    = 10'h020;
    localparam logic [9:0] GCL_OFS_AFL   = 10'h024;
    localparam logic [9:0] GCL_OFS_AFH   = 10'h028;
    localparam logic [9:0] GCL_OFS_LOCK  = 10'h02C;
    localparam logic [9:0] GCL_OFS_TRIG  = 10'h030;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          GCL_NPIN      = 18;
    localparam int          GCL_PORT_PINS = 16;
    localparam int          GCL_KEY_BIT   = 16;
    localparam int          GCL_MODE_W    = 2;
    localparam int          GCL_AF_W      = 4;
    localparam int          GCL_AF_PER_RG = 8;
    localparam logic [3:0]  GCL_BE_FULL   = 4'hF;
    localparam logic [1:0]  GCL_MODE_ALT  = 2'h2;
    localparam logic [3:0]  GCL_AF_EVT    = 4'h3;
    localparam logic [3:0]  GCL_AF_MCO    = 4'h6;
    localparam int          GCL_PIN_EVT_A = 4;
    localparam int          GCL_PIN_MCO_A = 13;
    localparam int          GCL_PIN_PB0   = 16;
    localparam int          GCL_PIN_PB1   = 17;
    localparam logic [4:0]  GCL_TRIG_RST  = 5'h00;
    localparam logic [4:0]  GCL_TRIG_MAX  = 5'h11;

    // ------------------------------------------------------------
    // reset values, index 0 is the first port
    // ------------------------------------------------------------
    localparam logic [1:0][31:0] GCL_RST_MODE  = {32'hFFFF_FFFF, 32'hFFFA_FFFF};
    localparam logic [1:0][31:0] GCL_RST_OTYPE = {32'h0000_0000, 32'h0000_0000};
    localparam logic [1:0][31:0] GCL_RST_SR    = {32'h0000_FFFF, 32'h0000_FFFF};
    localparam logic [1:0][31:0] GCL_RST_PUPD  = {32'h0000_0000, 32'h6409_0000};
    localparam logic [1:0][31:0] GCL_RST_DS    = {32'h0000_0000, 32'h0000_0000};
    localparam logic [1:0][31:0] GCL_RST_AFL   = {32'hFFFF_FFFF, 32'hFFFF_FFFF};
    localparam logic [1:0][31:0] GCL_RST_AFH   = {32'hFFFF_FFFF, 32'hFFFF_FF00};

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GCL_K_BIT,
        GCL_K_PAIR,
        GCL_K_AFL,
        GCL_K_AFH
    } gcl_kind_t;

    typedef enum logic [4:0] {
        GCL_S_IDLE = 5'h01,
        GCL_S_W1   = 5'h02,
        GCL_S_W0   = 5'h04,
        GCL_S_W1B  = 5'h08,
        GCL_S_DONE = 5'h10
    } gcl_lseq_t;

endpackage : gcl_pkg

//--- hw/gcl_lock_seq.sv
/*
 * lock register of one port: the pin lock bits and the key-setting sequence.
 * assumes the caller gives one-cycle strobes for taken full-word writes and for taken reads of any width to this register.
 */
`timescale 1ns/10ps
module gcl_lock_seq (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [31:0]       wdata_i,
    output logic                   lock_key_bit_o,
    output logic      [15:0]       pin_lock_bits_o
);
    import gcl_pkg::*;

    typedef struct packed {
        gcl_lseq_t   seq;
        logic [15:0] pins;
    } gcl_lock_st_t;

    localparam gcl_lock_st_t GCL_LOCK_RST = '{seq: GCL_S_IDLE, pins: '0};

    gcl_lock_st_t st;
    gcl_lock_st_t next_st;
    logic         same;
    logic         kbit;
    logic         key;

    assign key             = (st.seq == GCL_S_DONE);
    assign lock_key_bit_o  = key;
    assign pin_lock_bits_o = st.pins;
    assign same            = (wdata_i[15:0] == st.pins);
    assign kbit            = wdata_i[GCL_KEY_BIT];

    // ------------------------------------------------------------
    // sequence w1, w0, w1, r0
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_i && !key) begin
            next_st.pins = wdata_i[15:0];
            unique case (st.seq)
                GCL_S_IDLE: next_st.seq = kbit ? GCL_S_W1 : GCL_S_IDLE;
                GCL_S_W1:   next_st.seq = kbit ? GCL_S_W1 :
                                          (same ? GCL_S_W0 : GCL_S_IDLE);
                GCL_S_W0:   next_st.seq = (kbit && same) ? GCL_S_W1B :
                                          GCL_S_IDLE;
                GCL_S_W1B:  next_st.seq = kbit ? GCL_S_W1 : GCL_S_IDLE;
                GCL_S_DONE: next_st.seq = GCL_S_DONE;
            endcase
        end else if (rd_i && !key) begin
            // the read itself still returns a clear key, as the sequence demands
            next_st.seq = (st.seq == GCL_S_W1B) ? GCL_S_DONE : GCL_S_IDLE;
        end
    end

    // only the reset leaves the done state
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= GCL_LOCK_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_last_write;
        wr_i && !key && kbit && same && st.seq == GCL_S_W0;
    endsequence

    sequence s_closing_read;
        rd_i && !wr_i;
    endsequence

    a_order_armed: assert property (s_last_write |=> st.seq == GCL_S_W1B)
        else $error("third write did not arm the order");
    a_key_after_order: assert property (s_closing_read ##0 (st.seq == GCL_S_W1B) |=> key)
        else $error("key not set after a complete order");
    a_key_rise_cause: assert property ($rose(key) |-> $past(rd_i) && $past(st.seq) == GCL_S_W1B)
        else $error("key set without the closing read");
    a_key_stays_set: assert property (key |=> key)
        else $error("key cleared without reset");
    a_pins_frozen: assert property (key |=> $stable(st.pins))
        else $error("pin lock bits changed while key set");
    a_pins_changed: assert property (wr_i && !key && !same |=> st.seq != GCL_S_W0
                                                          && st.seq != GCL_S_W1B)
        else $error("order advanced with changed pin lock bits");

endmodule : gcl_lock_seq

//--- hw/gcl_port_top.sv
/*
 * configuration registers, pin locks and alternate routing of two ports.
 * assumes an avalon-mm master with full 32-bit word accesses and inputs synchronous to ref_clk_i.
 */
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
// Notes on behaviour
// - the key bit at bit 16 is set only after write key one, write key zero, write key one, read.
// - once set the key bit stays set until a system reset.
// - the sixteen pin lock bits take writes only while the key bit is clear.
// - the order counts only if the pin lock bits keep one value through all of it.
// - with the key clear every configuration and alternate field stays writable.
// - with the key set, the fields of each pin whose lock bit is set refuse writes.
// - the first port decodes at 0x4000_1C00 and the second at 0x4000_2000.
// - alternate three on A4, B0 or B1 routes the core event output to that pin.
// - alternate six on A13 drives the clock output onto that pin.
// - any of A0 to A15, B0 or B1 can be the analog conversion trigger.
`timescale 1ns/10ps
module gcl_port_top (
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_i,
    input  wire logic [31:0]            avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic      [31:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic                   core_event_output_i,
    input  wire logic                   clock_output_pin_signal_i,
    input  wire logic [gcl_pkg::GCL_NPIN-1:0] pin_in_i,
    output logic      [gcl_pkg::GCL_NPIN-1:0] pin_alt_out_o,
    output logic      [gcl_pkg::GCL_NPIN-1:0] pin_alt_oe_o,
    output logic                        adc_ext_trig_o
);
    import gcl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                       waitreq;
        logic [31:0]                rdata;
        logic [1:0][31:0]           mode;
        logic [1:0][31:0]           otype;
        logic [1:0][31:0]           sr;
        logic [1:0][31:0]           pupd;
        logic [1:0][31:0]           ds;
        logic [1:0][31:0]           afl;
        logic [1:0][31:0]           afh;
        logic [4:0]                 trig_sel;
        logic                       trig;
        logic [GCL_NPIN-1:0]        alt_out;
        logic [GCL_NPIN-1:0]        alt_oe;
    } gcl_top_st_t;

    localparam gcl_top_st_t GCL_TOP_RST = '{
        waitreq:  1'b1,
        rdata:    '0,
        mode:     GCL_RST_MODE,
        otype:    GCL_RST_OTYPE,
        sr:       GCL_RST_SR,
        pupd:     GCL_RST_PUPD,
        ds:       GCL_RST_DS,
        afl:      GCL_RST_AFL,
        afh:      GCL_RST_AFH,
        trig_sel: GCL_TRIG_RST,
        trig:     1'b0,
        alt_out:  '0,
        alt_oe:   '0
    };

    gcl_top_st_t st;
    gcl_top_st_t next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // writable bits of one register, given the pins that are frozen
    function automatic logic [31:0] gcl_wmask(input logic [15:0] frozen,
                                              input gcl_kind_t   kind);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < GCL_PORT_PINS; i++) begin
            unique case (kind)
                GCL_K_BIT:  m[i] = !frozen[i];
                GCL_K_PAIR: m[GCL_MODE_W*i +: GCL_MODE_W] = {GCL_MODE_W{!frozen[i]}};
                GCL_K_AFL:  if (i < GCL_AF_PER_RG) begin
                    m[GCL_AF_W*i +: GCL_AF_W] = {GCL_AF_W{!frozen[i]}};
                end
                GCL_K_AFH:  if (i >= GCL_AF_PER_RG) begin
                    m[GCL_AF_W*(i-GCL_AF_PER_RG) +: GCL_AF_W] = {GCL_AF_W{!frozen[i]}};
                end
            endcase
        end
        return m;
    endfunction : gcl_wmask

    function automatic logic [31:0] gcl_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction : gcl_merge

    // alternate selector of one pin in one port
    function automatic logic [3:0] gcl_af_of(input logic [31:0] afl,
                                             input logic [31:0] afh,
                                             input int          idx);
        if (idx < GCL_AF_PER_RG) begin
            return afl[GCL_AF_W*idx +: GCL_AF_W];
        end
        return afh[GCL_AF_W*(idx-GCL_AF_PER_RG) +: GCL_AF_W];
    endfunction : gcl_af_of

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic                  take;
    logic                  hit_a;
    logic                  hit_b;
    logic                  hit;
    logic                  psel;
    logic                  full;
    logic [GCL_OFS_W-1:0]  ofs;
    logic [1:0]            lock_wr;
    logic [1:0]            lock_rd;
    logic [1:0]            key;
    logic [1:0][15:0]      pin_lock;

    assign take  = (avs_read_i || avs_write_i) && st.waitreq;
    assign hit_a = ((avs_address_i & GCL_WIN_MASK) == GCL_BASE_A);
    assign hit_b = ((avs_address_i & GCL_WIN_MASK) == GCL_BASE_B);
    assign hit   = hit_a || hit_b;
    assign psel  = hit_b;
    assign ofs   = avs_address_i[GCL_OFS_W-1:0];
    // narrow writes are dropped rather than merged
    assign full  = (avs_byteenable_i == GCL_BE_FULL);

    for (genvar g = 0; g < 2; g++) begin : g_lock
        assign lock_wr[g] = take && avs_write_i && full && ofs == GCL_OFS_LOCK
                            && (g == 0 ? hit_a : hit_b);
        assign lock_rd[g] = take && avs_read_i && ofs == GCL_OFS_LOCK
                            && (g == 0 ? hit_a : hit_b);
        gcl_lock_seq u_lock (
            .ref_clk_i       (ref_clk_i),
            .reset_i         (reset_i),
            .wr_i            (lock_wr[g]),
            .rd_i            (lock_rd[g]),
            .wdata_i         (avs_writedata_i),
            .lock_key_bit_o  (key[g]),
            .pin_lock_bits_o (pin_lock[g])
        );
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] frozen;
        logic [31:0] wd;
        logic [3:0]  af;
        int          port;
        int          idx;
        frozen  = key[psel] ? pin_lock[psel] : '0;
        wd      = avs_writedata_i;
        af      = '0;
        port    = 0;
        idx     = 0;
        next_st = st;
        // one cycle of waitrequest high, then one cycle low per access
        next_st.waitreq = !take;

        if (take && avs_read_i) begin
            next_st.rdata = '0;
            if (hit) begin
                unique case (ofs)
                    GCL_OFS_MODE:  next_st.rdata = st.mode[psel];
                    GCL_OFS_OTYPE: next_st.rdata = st.otype[psel];
                    GCL_OFS_SR:    next_st.rdata = st.sr[psel];
                    GCL_OFS_PUPD:  next_st.rdata = st.pupd[psel];
                    GCL_OFS_DS:    next_st.rdata = st.ds[psel];
                    GCL_OFS_AFL:   next_st.rdata = st.afl[psel];
                    GCL_OFS_AFH:   next_st.rdata = st.afh[psel];
                    GCL_OFS_LOCK:  next_st.rdata = 32'({key[psel], pin_lock[psel]});
                    GCL_OFS_TRIG:  next_st.rdata = psel ? '0 : 32'(st.trig_sel);
                    default:       next_st.rdata = '0;
                endcase
            end
        end

        if (take && avs_write_i && hit && full) begin
            unique case (ofs)
                GCL_OFS_MODE:  next_st.mode[psel]  = gcl_merge(st.mode[psel], wd,
                                   gcl_wmask(frozen, GCL_K_PAIR));
                GCL_OFS_OTYPE: next_st.otype[psel] = gcl_merge(st.otype[psel], wd,
                                   gcl_wmask(frozen, GCL_K_BIT));
                GCL_OFS_SR:    next_st.sr[psel]    = gcl_merge(st.sr[psel], wd,
                                   gcl_wmask(frozen, GCL_K_BIT));
                GCL_OFS_PUPD:  next_st.pupd[psel]  = gcl_merge(st.pupd[psel], wd,
                                   gcl_wmask(frozen, GCL_K_PAIR));
                GCL_OFS_DS:    next_st.ds[psel]    = gcl_merge(st.ds[psel], wd,
                                   gcl_wmask(frozen, GCL_K_BIT));
                GCL_OFS_AFL:   next_st.afl[psel]   = gcl_merge(st.afl[psel], wd,
                                   gcl_wmask(frozen, GCL_K_AFL));
                GCL_OFS_AFH:   next_st.afh[psel]   = gcl_merge(st.afh[psel], wd,
                                   gcl_wmask(frozen, GCL_K_AFH));
                GCL_OFS_TRIG:  if (!psel) begin
                    next_st.trig_sel = wd[4:0];
                end
                default: ;
            endcase
        end

        // alternate routing, registered so the pads see clean levels
        for (int p = 0; p < GCL_NPIN; p++) begin
            port = (p < GCL_PORT_PINS) ? 0 : 1;
            idx  = (p < GCL_PORT_PINS) ? p : p - GCL_PORT_PINS;
            af   = gcl_af_of(st.afl[port], st.afh[port], idx);
            next_st.alt_oe[p]  = 1'b0;
            next_st.alt_out[p] = 1'b0;
            if (st.mode[port][GCL_MODE_W*idx +: GCL_MODE_W] == GCL_MODE_ALT) begin
                if ((p == GCL_PIN_EVT_A || p == GCL_PIN_PB0 || p == GCL_PIN_PB1)
                    && af == GCL_AF_EVT) begin
                    next_st.alt_oe[p]  = 1'b1;
                    next_st.alt_out[p] = core_event_output_i;
                end
                if (p == GCL_PIN_MCO_A && af == GCL_AF_MCO) begin
                    next_st.alt_oe[p]  = 1'b1;
                    next_st.alt_out[p] = clock_output_pin_signal_i;
                end
            end
        end

        // out-of-range selections give a quiet trigger
        next_st.trig = (st.trig_sel <= GCL_TRIG_MAX) ? pin_in_i[st.trig_sel] : 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= GCL_TOP_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata_o    = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign pin_alt_out_o     = st.alt_out;
    assign pin_alt_oe_o      = st.alt_oe;
    assign adc_ext_trig_o    = st.trig;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_mode_a_write;
        take && avs_write_i && hit_a && full && ofs == GCL_OFS_MODE;
    endsequence

    sequence s_lock_a_read;
        take && avs_read_i && hit_a && ofs == GCL_OFS_LOCK;
    endsequence

    a_bus_answer: assert property (take |=> !st.waitreq ##1 st.waitreq)
        else $error("waitrequest did not pulse low once");
    a_open_write: assert property (s_mode_a_write and !key[0] |=>
                                   st.mode[0] == $past(avs_writedata_i))
        else $error("open mode register not written");
    a_frozen_pin: assert property (s_mode_a_write and key[0] && pin_lock[0][GCL_PIN_EVT_A]
            |=> $stable(st.mode[0][GCL_MODE_W*GCL_PIN_EVT_A +: GCL_MODE_W]))
        else $error("locked pin mode field changed");
    a_lock_read: assert property (s_lock_a_read |=>
                                  st.rdata == 32'({$past(key[0]), $past(pin_lock[0])}))
        else $error("lock register read wrong");
    a_unmapped_read: assert property (take && avs_read_i && !hit |=> st.rdata == '0)
        else $error("unmapped read not zero");
    a_event_route: assert property (
            st.mode[0][GCL_MODE_W*GCL_PIN_EVT_A +: GCL_MODE_W] == GCL_MODE_ALT
            && gcl_af_of(st.afl[0], st.afh[0], GCL_PIN_EVT_A) == GCL_AF_EVT
            |=> st.alt_oe[GCL_PIN_EVT_A]
            && st.alt_out[GCL_PIN_EVT_A] == $past(core_event_output_i))
        else $error("event output not routed");
    a_clock_route: assert property (
            st.mode[0][GCL_MODE_W*GCL_PIN_MCO_A +: GCL_MODE_W] == GCL_MODE_ALT
            && gcl_af_of(st.afl[0], st.afh[0], GCL_PIN_MCO_A) == GCL_AF_MCO
            |=> st.alt_oe[GCL_PIN_MCO_A]
            && st.alt_out[GCL_PIN_MCO_A] == $past(clock_output_pin_signal_i))
        else $error("clock output not routed");
    a_trig_follow: assert property (st.trig_sel <= GCL_TRIG_MAX && pin_in_i[st.trig_sel] |=>
                                    st.trig)
        else $error("trigger does not follow selected pin");
    a_trig_quiet: assert property (st.trig_sel > GCL_TRIG_MAX || !pin_in_i[st.trig_sel] |=>
                                   !st.trig)
        else $error("trigger high without selected pin");

endmodule : gcl_port_top

//--- tb/gcl_pin_model.sv
/*
 * pin side model: peripheral event and clock-out signals and the pin levels.
 * assumes the bench sets event and pin levels; clock-out toggles every bus clock.
 */
`timescale 1ns/10ps
module gcl_pin_model (
    input  wire logic        ref_clk_i,
    input  wire logic        evt_lvl_i,
    input  wire logic [17:0] pin_lvl_i,
    output logic             evt_o,
    output logic             mco_o,
    output logic      [17:0] pins_o
);
    // a live toggle on clock-out so a stuck route cannot pass
    initial mco_o = 1'b0;
    always @(posedge ref_clk_i) begin
        mco_o <= ~mco_o;
    end
    assign evt_o  = evt_lvl_i;
    assign pins_o = pin_lvl_i;
endmodule : gcl_pin_model

//--- tb/tb.sv
/*
 * self-checking bench for the port configuration, lock and alternate routing block.
 * assumes the package and the pin model are compiled first.
 */
`timescale 1ns/10ps
module tb;
    import gcl_pkg::*;
    localparam logic [31:0] LK = GCL_BASE_A + {22'h0, GCL_OFS_LOCK};
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, evt = 1'b0, m;
    logic [31:0] adr = 32'h0000_0000, wd = 32'h0000_0000, rdata, q;
    logic [3:0]  be = 4'hF;
    logic [17:0] lvl = 18'h0_0000, pins, out, oe;
    logic        wreq, clock_output_pin_signal, ev, trig;
    int          mismatches = 0, num_checks = 0;
    always #5 clk = ~clk;
    gcl_pin_model pin_u (.ref_clk_i(clk), .evt_lvl_i(evt), .pin_lvl_i(lvl), .evt_o(ev),
        .mco_o(clock_output_pin_signal), .pins_o(pins));
    gcl_port_top dut_u (.ref_clk_i(clk), .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .core_event_output_i(ev), .clock_output_pin_signal_i(clock_output_pin_signal),
        .pin_in_i(pins), .pin_alt_out_o(out), .pin_alt_oe_o(oe), .adc_ext_trig_o(trig));
    function automatic logic [31:0] ad(input logic p, input logic [9:0] o);
        return (p ? GCL_BASE_B : GCL_BASE_A) + {22'h0, o};
    endfunction : ad
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] b);
        @(posedge clk);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic w32(input logic [31:0] a, d);
        bus(1'b1, a, d, 4'hF);
    endtask : w32
    task automatic rc(input string n, input logic [31:0] a, e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(n, e, q);
    endtask : rc
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rc("mode_a", ad(0, GCL_OFS_MODE), 32'hFFFA_FFFF);
        rc("lock_rst", LK, 32'h0000_0000);
        rc("unmapped", 32'h4000_3000, 32'h0000_0000);
        w32(ad(0, GCL_OFS_DS), 32'h0000_00A5);
        w32(ad(1, GCL_OFS_DS), 32'h0000_005A);
        bus(1'b1, ad(0, GCL_OFS_DS), 32'h0000_FFFF, 4'h3);
        rc("ds_a", ad(0, GCL_OFS_DS), 32'h0000_00A5);
        rc("ds_b", ad(1, GCL_OFS_DS), 32'h0000_005A);
        // pin locks change inside the order, so the key must stay clear
        w32(LK, 32'h0001_2010);
        w32(LK, 32'h0000_2011);
        w32(LK, 32'h0001_2010);
        rc("lock_bad", LK, 32'h0000_2010);
        rc("lock_bad2", LK, 32'h0000_2010);
        w32(ad(0, GCL_OFS_OTYPE), 32'h0000_0002);
        w32(ad(0, GCL_OFS_MODE), 32'h0800_0200);
        rc("mode_open", ad(0, GCL_OFS_MODE), 32'h0800_0200);
        w32(ad(0, GCL_OFS_AFL), 32'hFFF3_FFFF);
        w32(ad(0, GCL_OFS_AFH), 32'hFF6F_FF00);
        w32(ad(1, GCL_OFS_AFL), 32'hFFFF_FFF3);
        w32(ad(1, GCL_OFS_MODE), 32'hFFFF_FFFE);
        repeat (3) @(posedge clk);
        chk("alt_oe", 32'h0001_2010, {14'h0, oe});
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            evt <= i[0];
            repeat (3) @(posedge clk);
            chk("evt_a4", {31'h0, i[0]}, {31'h0, out[4]});
            chk("evt_b0", {31'h0, i[0]}, {31'h0, out[16]});
        end
        m = out[13];
        @(posedge clk);
        chk("mco_a13", 32'h0000_0001, {31'h0, out[13] ^ m});
        for (int s = 0; s < 18; s += 17) begin
            w32(ad(0, GCL_OFS_TRIG), 32'(s));
            lvl <= 18'h0_0001 << s;
            repeat (3) @(posedge clk);
            chk("trig_hi", 32'h0000_0001, {31'h0, trig});
            lvl <= 18'h0_0000;
            repeat (3) @(posedge clk);
            chk("trig_lo", 32'h0000_0000, {31'h0, trig});
        end
        w32(LK, 32'h0001_2010);
        w32(LK, 32'h0000_2010);
        w32(LK, 32'h0001_2010);
        rc("lock_r0", LK, 32'h0000_2010);
        rc("lock_key", LK, 32'h0001_2010);
        w32(LK, 32'h0000_0000);
        rc("lock_hold", LK, 32'h0001_2010);
        w32(ad(0, GCL_OFS_MODE), 32'hFFFF_FFFF);
        rc("mode_lock", ad(0, GCL_OFS_MODE), 32'hFBFF_FEFF);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc("lock_clr", LK, 32'h0000_0000);
        close_out;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        close_out;
    end
endmodule : tb
